// ---- shared/fsic_regs.vh ----
// Constants of the flash security and initialization control block.
`ifndef FSIC_REGS_VH
`define FSIC_REGS_VH
`define FSIC_ADDR_W 24
`define FSIC_ADDR_KEY0 24'hFF_FE00
`define FSIC_ADDR_PPROT 24'hFF_FE0C
`define FSIC_ADDR_EPROT 24'hFF_FE0D
`define FSIC_ADDR_OPT 24'hFF_FE0E
`define FSIC_ADDR_SEC 24'hFF_FE0F
`define FSIC_ADDR_BCFG 24'hFF_FE10
`define FSIC_SEC_UNSECURED 2'h2
`define FSIC_SEC_SECURED 2'h3
`define FSIC_BACKDOOR_KEY_ENABLE_FIELD_ENABLED 2'h2
`define FSIC_SEC_LSB 0
`define FSIC_SEC_MSB 1
`define FSIC_BACKDOOR_KEY_ENABLE_FIELD_LSB 6
`define FSIC_BACKDOOR_KEY_ENABLE_FIELD_MSB 7
`define FSIC_DEF_SEC 8'hFF
`define FSIC_DEF_PROT 8'h00
`define FSIC_DEF_OPT 8'hFF
`define FSIC_DEF_BCFG 8'h00
`define FSIC_KEY_ZERO 16'h0000
`define FSIC_KEY_ONES 16'hFFFF
`define FSIC_NKEYS 4
`define FSIC_NLOADS 3'h6
`define FSIC_HOLD_LOADS 3'h2
`define FSIC_CMD_VERIFY_KEY 8'h0C
`define FSIC_CMD_ERASE_ALL 8'h08
`define FSIC_CMD_ERASE_SECTOR 8'h0A
`define FSIC_CMD_PROGRAM 8'h06
`endif

// ---- logic/fsic_key_cmp.v ----
// One backdoor key comparator slot.
`timescale 1ns/10ps
`include "fsic_regs.vh"
module fsic_key_cmp (
	input wire [15:0] stored_key, // Key held in the configuration field.
	input wire [15:0] cand_key, // Key presented by software.
	output wire match // Key valid and equal.
);
	assign match = (stored_key == cand_key) && (stored_key != `FSIC_KEY_ZERO) && (stored_key != `FSIC_KEY_ONES);
endmodule // fsic_key_cmp

// ---- logic/fsic_ctrl.v ----
// Flash controller low-power, security and reset initialization control.
`timescale 1ns/10ps
`include "fsic_regs.vh"
// Summary of operation
// - Controller runs normally during wait; command complete interrupt can wake the chip.
// - Stop request during a running command waits until the command finishes.
// - Security register loads from the stored security byte during reset.
// - Newly programmed security byte takes effect only after the next reset.
// - Verify-backdoor command is allowed only while the key enable field is enabled.
// - All four keys matching forces the security state field to binary 10.
// - Stored keys of all zeros or all ones never match.
// - Flash and EEPROM reads are blocked and invalid while verify-backdoor runs.
// - An illegal key rejects every later verify-backdoor until reset.
// - Verify-backdoor changes no stored security byte, keys or protection.
// - Once unsecured, the security sector may be erased and reprogrammed.
// - Secured part in special single-chip mode may be unsecured by debug mass erase.
// - Commands are accepted or rejected by operating mode and security state.
// - Reset initialization loads block parameters, both protections, option and security.
// - Any initialization error falls back to fully protected, secured defaults.
// - A double-bit fault during initialization sets both error status bits.
// - Command complete flag stays low during initialization and rises at its end.
// - CPU accesses stall during part of initialization; reads allowed afterwards.
// - Reset aborts any running command at once.
// - Command interrupt requests when complete flag and its enable are both set.
module fsic_ctrl (
	input wire clock, // System bus clock.
	input wire rst, // Synchronous reset, active high.
	input wire clk_en, // Clock enable; freezes all state when low, except that reset still acts.
	input wire stop_req, // Stop mode request from the power controller.
	input wire command_complete_irq_enable, // Command complete interrupt enable.
	input wire special_mode, // Special single-chip mode active.
	input wire bdm_active, // Background debug mode active.
	input wire cmd_launch, // Pulse: launch a command.
	input wire [7:0] cmd_code, // Command code.
	input wire [23:0] cmd_addr, // Command target address.
	input wire [63:0] cand_keys, // Four candidate keys, key 0 in the low bits.
	input wire cmd_done, // Pulse: flash array finished the running operation.
	input wire [7:0] nvm_rdata, // Configuration field read data.
	input wire nvm_rvalid, // Read data valid.
	input wire nvm_ecc_single, // Single-bit fault corrected on this read.
	input wire nvm_ecc_double, // Double-bit fault on this read.
	input wire [63:0] stored_keys, // Stored backdoor keys, key 0 in the low bits.
	output reg nvm_rd_reg, // Initialization read request.
	output reg [23:0] nvm_addr_reg, // Initialization read address.
	output reg command_complete_flag, // Command complete flag.
	output reg cmd_irq_reg, // Command interrupt request.
	output reg stop_ack_reg, // Stop may be entered.
	output reg cpu_stall_reg, // Hold off CPU accesses.
	output reg read_block_reg, // Flash and EEPROM reads return invalid data.
	output reg cmd_start_reg, // Pulse: accepted command sent to the array.
	output reg cmd_accerr_reg, // Access error of the last launch.
	output reg [1:0] memory_controller_error_bits, // Error status bits.
	output reg [7:0] security_register, // Live security register.
	output reg [7:0] pflash_protection_register, // P-Flash protection.
	output reg [7:0] eeprom_protection_register, // EEPROM protection.
	output reg [7:0] nonvolatile_option_register, // Option register.
	output reg [7:0] block_config_reg, // Block configuration parameters.
	output reg key_locked_reg // Verify-backdoor disabled until reset.
);
	localparam ST_INIT = 4'b0001;
	localparam ST_IDLE = 4'b0010;
	localparam ST_BUSY = 4'b0100;
	localparam ST_KEY = 4'b1000;

	reg [3:0] state_reg;
	reg [2:0] load_idx_reg;
	reg init_err_reg;
	wire [3:0] key_match;
	wire all_match;
	wire [1:0] security_state_field;
	wire [1:0] backdoor_key_enable_field;
	wire secured;
	wire is_verify;
	reg cmd_ok;
	reg [23:0] load_addr;

	genvar gi;
	generate
		for (gi = 0; gi < `FSIC_NKEYS; gi = gi + 1) begin : g_key
			fsic_key_cmp u_cmp (
				.stored_key(stored_keys[gi*16 +: 16]),
				.cand_key(cand_keys[gi*16 +: 16]),
				.match(key_match[gi])
			);
		end
	endgenerate

	assign all_match = &key_match;
	assign security_state_field = security_register[`FSIC_SEC_MSB:`FSIC_SEC_LSB];
	assign backdoor_key_enable_field = security_register[`FSIC_BACKDOOR_KEY_ENABLE_FIELD_MSB:`FSIC_BACKDOOR_KEY_ENABLE_FIELD_LSB];
	assign secured = (security_state_field != `FSIC_SEC_UNSECURED);
	assign is_verify = (cmd_code == `FSIC_CMD_VERIFY_KEY);

	// Load order: block parameters, two protections, option, then security last.
	always @* begin
		case (load_idx_reg)
		3'h0: load_addr = `FSIC_ADDR_BCFG;
		3'h1: load_addr = `FSIC_ADDR_PPROT;
		3'h2: load_addr = `FSIC_ADDR_EPROT;
		3'h3: load_addr = `FSIC_ADDR_OPT;
		default: load_addr = `FSIC_ADDR_SEC;
		endcase
	end

	// Command acceptance by mode and security state.
	always @* begin
		cmd_ok = 1'b1;
		if (is_verify) begin
			cmd_ok = (backdoor_key_enable_field == `FSIC_BACKDOOR_KEY_ENABLE_FIELD_ENABLED) && !key_locked_reg;
		end else if (secured) begin
			// Apart from verify-backdoor, secured parts only take a mass erase from debug in special mode.
			cmd_ok = special_mode && bdm_active && (cmd_code == `FSIC_CMD_ERASE_ALL);
		end else if ((cmd_code == `FSIC_CMD_ERASE_SECTOR) || (cmd_code == `FSIC_CMD_PROGRAM)) begin
			cmd_ok = 1'b1;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			// Any running command is dropped here and the array is left as it stands.
			state_reg <= ST_INIT;
			load_idx_reg <= 3'h0;
			init_err_reg <= 1'b0;
			nvm_rd_reg <= 1'b0;
			nvm_addr_reg <= `FSIC_ADDR_BCFG;
			command_complete_flag <= 1'b0;
			cmd_irq_reg <= 1'b0;
			stop_ack_reg <= 1'b0;
			cpu_stall_reg <= 1'b1;
			read_block_reg <= 1'b0;
			cmd_start_reg <= 1'b0;
			cmd_accerr_reg <= 1'b0;
			memory_controller_error_bits <= 2'h0;
			security_register <= `FSIC_DEF_SEC;
			pflash_protection_register <= `FSIC_DEF_PROT;
			eeprom_protection_register <= `FSIC_DEF_PROT;
			nonvolatile_option_register <= `FSIC_DEF_OPT;
			block_config_reg <= `FSIC_DEF_BCFG;
			key_locked_reg <= 1'b0;
		end else if (clk_en) begin
			cmd_start_reg <= 1'b0;
			cmd_irq_reg <= command_complete_flag && command_complete_irq_enable;
			stop_ack_reg <= stop_req && command_complete_flag;
			case (state_reg)
			ST_INIT: begin
				nvm_rd_reg <= 1'b1;
				nvm_addr_reg <= load_addr;
				if (nvm_rvalid && nvm_rd_reg) begin
					nvm_rd_reg <= 1'b0;
					if (nvm_ecc_double) begin
						memory_controller_error_bits <= 2'h3;
					end
					case (load_idx_reg)
					3'h0: block_config_reg <= nvm_rdata;
					3'h1: pflash_protection_register <= nvm_rdata;
					3'h2: eeprom_protection_register <= nvm_rdata;
					3'h3: nonvolatile_option_register <= nvm_rdata;
					default: security_register <= nvm_rdata;
					endcase
					if (load_idx_reg == `FSIC_HOLD_LOADS) begin
						cpu_stall_reg <= 1'b0;
					end
					if (nvm_ecc_double || init_err_reg) begin
						init_err_reg <= 1'b1;
					end
					if (load_idx_reg == (`FSIC_NLOADS - 3'h2)) begin
						if (nvm_ecc_double || init_err_reg) begin
							block_config_reg <= `FSIC_DEF_BCFG;
							pflash_protection_register <= `FSIC_DEF_PROT;
							eeprom_protection_register <= `FSIC_DEF_PROT;
							nonvolatile_option_register <= `FSIC_DEF_OPT;
							security_register <= `FSIC_DEF_SEC;
						end
						cpu_stall_reg <= 1'b0;
						command_complete_flag <= 1'b1;
						state_reg <= ST_IDLE;
					end else begin
						load_idx_reg <= load_idx_reg + 3'h1;
					end
				end
			end
			ST_IDLE: begin
				nvm_rd_reg <= 1'b0;
				if (cmd_launch) begin
					cmd_accerr_reg <= !cmd_ok;
					if (cmd_ok && is_verify) begin
						command_complete_flag <= 1'b0;
						read_block_reg <= 1'b1;
						state_reg <= ST_KEY;
					end else if (cmd_ok) begin
						command_complete_flag <= 1'b0;
						cmd_start_reg <= 1'b1;
						state_reg <= ST_BUSY;
					end
				end
			end
			ST_BUSY: begin
				if (cmd_done) begin
					command_complete_flag <= 1'b1;
					state_reg <= ST_IDLE;
				end
			end
			ST_KEY: begin
				// Only the live state changes; stored bytes and protection stay.
				if (all_match) begin
					security_register[`FSIC_SEC_MSB:`FSIC_SEC_LSB] <= `FSIC_SEC_UNSECURED;
				end else begin
					key_locked_reg <= 1'b1;
				end
				read_block_reg <= 1'b0;
				command_complete_flag <= 1'b1;
				state_reg <= ST_IDLE;
			end
			default: state_reg <= ST_INIT;
			endcase
		end
	end
endmodule // fsic_ctrl

// ---- dv/fsic_ctrl_chk.sv ----
// Port assertions of the flash security and initialization control.
`timescale 1ns/10ps
module fsic_ctrl_chk (
	input wire clock, // Clock.
	input wire rst, // Reset.
	input wire stop_req, // Stop request.
	input wire command_complete_irq_enable, // Irq enable.
	input wire cmd_launch, // Launch.
	input wire [7:0] cmd_code, // Code.
	input wire cmd_done, // Array done.
	input wire command_complete_flag, // Flag.
	input wire cmd_irq_reg, // Irq.
	input wire stop_ack_reg, // Stop ack.
	input wire cpu_stall_reg, // Stall.
	input wire read_block_reg, // Read block.
	input wire cmd_start_reg, // Start.
	input wire key_locked_reg, // Lock.
	input wire [7:0] security_register // Security.
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_irq; command_complete_flag && command_complete_irq_enable |=> cmd_irq_reg; endproperty
	a_irq: assert property (p_irq) else $error("irq missing");
	property p_stop; stop_req && !command_complete_flag |=> !stop_ack_reg; endproperty
	a_stop: assert property (p_stop) else $error("stop ack while busy");
	property p_rb; read_block_reg |-> !command_complete_flag; endproperty
	a_rb: assert property (p_rb) else $error("read block while idle");
	property p_lock; key_locked_reg |=> key_locked_reg; endproperty
	a_lock: assert property (p_lock) else $error("key lock dropped");
	property p_stall; command_complete_flag |-> !cpu_stall_reg; endproperty
	a_stall: assert property (p_stall) else $error("stall after init");
	property p_sec; command_complete_flag && $past(command_complete_flag) |-> $stable(security_register); endproperty
	a_sec: assert property (p_sec) else $error("security changed while idle");
	property p_rej; cmd_launch && !command_complete_flag |=> !cmd_start_reg; endproperty
	a_rej: assert property (p_rej) else $error("busy launch started");
	property p_done; cmd_done && !command_complete_flag && !read_block_reg && !cpu_stall_reg |=> command_complete_flag;
	endproperty
	a_done: assert property (p_done) else $error("flag not set on done");
	property p_vk; cmd_launch && command_complete_flag && cmd_code == 8'h0C && !key_locked_reg
		&& security_register[7:6] == 2'h2 |=> read_block_reg ##1 (command_complete_flag && !read_block_reg); endproperty
	a_vk: assert property (p_vk) else $error("verify timing wrong");
endmodule // fsic_ctrl_chk
bind fsic_ctrl fsic_ctrl_chk u_chk (.clock, .rst, .stop_req, .command_complete_irq_enable, .cmd_launch, .cmd_code,
	.cmd_done, .command_complete_flag, .cmd_irq_reg, .stop_ack_reg, .cpu_stall_reg, .read_block_reg, .cmd_start_reg,
	.key_locked_reg, .security_register);

// ---- dv/fsic_nvm_model.sv ----
// Model of the configuration field reads and the flash array.
`timescale 1ns/10ps
module fsic_nvm_model (
	input wire clock, // Clock.
	input wire nvm_rd_reg, // Read request.
	input wire [23:0] nvm_addr_reg, // Read address.
	input wire cmd_start_reg, // Array start.
	input wire [7:0] sec_byte, // Stored security byte.
	input wire dbl, // Inject double faults.
	output reg [7:0] nvm_rdata, // Read data.
	output reg nvm_rvalid, // Read valid.
	output reg nvm_ecc_double, // Double fault.
	output reg cmd_done // Array done.
);
	reg [3:0] wait_reg, run_reg;
	initial begin
		{nvm_rdata, nvm_rvalid, nvm_ecc_double, cmd_done, wait_reg, run_reg} = 22'h00_0000;
	end
	// Data toggles outside valid cycles so a stale byte is never mistaken for an answer.
	always @(posedge clock) begin
		nvm_rvalid <= 1'h0;
		nvm_ecc_double <= 1'h0;
		nvm_rdata <= ~nvm_rdata;
		cmd_done <= run_reg == 4'h1;
		run_reg <= cmd_start_reg ? 4'h6 : run_reg - (run_reg != 4'h0);
		wait_reg <= (nvm_rd_reg && !nvm_rvalid) ? wait_reg + 4'h1 : 4'h0;
		if (wait_reg == 4'h2) begin
			nvm_rvalid <= 1'h1;
			nvm_rdata <= nvm_addr_reg[3:0] == 4'hF ? sec_byte : nvm_addr_reg[7:0];
			nvm_ecc_double <= dbl;
			wait_reg <= 4'h0;
		end
	end
endmodule // fsic_nvm_model

// ---- dv/test_fsic_ctrl.sv ----
// Self-checking testbench of the flash security and initialization control.
`timescale 1ns/10ps
module test_fsic_ctrl;
	localparam [63:0] KEYS = 64'h1234_5678_9ABC_DEF1;
	reg clock, rst, stop_req, irq_en, cmd_launch, dbl, sm;
	reg [7:0] cmd_code, sec_byte;
	reg [63:0] cand_keys, stored_keys;
	wire [7:0] nvm_rdata, sec, pprot, eprot, opt, bcfg;
	wire [1:0] errs;
	wire [23:0] nvm_addr;
	wire nvm_rd, nvm_rvalid, dbl_f, done, flag, irq, stop_ack, start, accerr, locked;
	integer err_count, comparisons, cycles, i;
	fsic_ctrl u_dut (.clock, .rst, .clk_en(1'h1), .stop_req, .command_complete_irq_enable(irq_en),
		.special_mode(sm), .bdm_active(sm), .cmd_launch, .cmd_code, .cmd_addr(24'h00_0000), .cand_keys,
		.cmd_done(done), .nvm_rdata, .nvm_rvalid, .nvm_ecc_single(1'h0), .nvm_ecc_double(dbl_f), .stored_keys,
		.nvm_rd_reg(nvm_rd), .nvm_addr_reg(nvm_addr), .command_complete_flag(flag), .cmd_irq_reg(irq),
		.stop_ack_reg(stop_ack), .cpu_stall_reg(), .read_block_reg(), .cmd_start_reg(start), .cmd_accerr_reg(accerr),
		.memory_controller_error_bits(errs), .security_register(sec), .pflash_protection_register(pprot),
		.eeprom_protection_register(eprot), .nonvolatile_option_register(opt), .block_config_reg(bcfg),
		.key_locked_reg(locked));
	fsic_nvm_model u_nvm (.clock, .nvm_rd_reg(nvm_rd), .nvm_addr_reg(nvm_addr), .cmd_start_reg(start), .sec_byte,
		.dbl, .nvm_rdata, .nvm_rvalid, .nvm_ecc_double(dbl_f), .cmd_done(done));
	task chk(input [63:0] s, input [63:0] e);
		comparisons = comparisons + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("Error at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task finish_test;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task wf;
		for (i = 0; i < 60 && flag !== 1'h1; i = i + 1) @(negedge clock);
		chk(flag, 1'h1);
	endtask
	task rs(input [7:0] s, input d);
		sec_byte = s;
		dbl = d;
		rst = 1'h1;
		repeat (12) @(negedge clock);
		rst = 1'h0;
		@(negedge clock);
		chk(flag, 1'h0);
		wf;
	endtask
	task go(input [7:0] c);
		cmd_code = c;
		cmd_launch = 1'h1;
		@(negedge clock);
		cmd_launch = 1'h0;
		repeat (2) @(negedge clock);
		wf;
	endtask
	task t_init;
		rs(8'h81, 1'h0);
		chk(sec, 8'h81);
		chk({pprot, eprot, opt, bcfg, errs}, 34'h0_3034_3840);
		$display("test init done");
	endtask
	task t_unsecure;
		cand_keys = KEYS;
		go(8'h0C);
		chk({sec, pprot, locked}, 17'h1_0418);
		go(8'h0A);
		chk(accerr, 1'h0);
		irq_en = 1'h1;
		cmd_code = 8'h06;
		cmd_launch = 1'h1;
		@(negedge clock);
		cmd_launch = 1'h0;
		@(negedge clock);
		stop_req = 1'h1;
		cmd_launch = 1'h1;
		@(negedge clock);
		cmd_launch = 1'h0;
		chk({flag, stop_ack}, 2'h0);
		wf;
		@(negedge clock);
		chk({stop_ack, irq}, 2'h3);
		stop_req = 1'h0;
		irq_en = 1'h0;
		$display("test unsecure done");
	endtask
	task t_keys;
		rs(8'h81, 1'h0);
		go(8'h06);
		chk(accerr, 1'h1);
		sm = 1'h1;
		go(8'h08);
		chk(accerr, 1'h0);
		sm = 1'h0;
		stored_keys = ~64'h0;
		cand_keys = ~64'h0;
		go(8'h0C);
		chk(sec, 8'h81);
		rs(8'h81, 1'h0);
		chk(locked, 1'h0);
		stored_keys = KEYS;
		cand_keys = KEYS ^ 64'h1;
		go(8'h0C);
		chk(locked, 1'h1);
		cand_keys = KEYS;
		go(8'h0C);
		chk(sec, 8'h81);
		chk(accerr, 1'h1);
		$display("test keys done");
	endtask
	task t_fault;
		rs(8'h82, 1'h1);
		chk({sec, pprot, eprot, opt, errs}, 34'h3_FC00_03FF);
		$display("test fault done");
	endtask
	initial begin
		clock = 1'h0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			err_count = err_count + 1;
			finish_test;
		end
	end
	initial begin
		{sm, stop_req, irq_en, cmd_launch, cmd_code} = 12'h000;
		stored_keys = KEYS;
		cand_keys = KEYS;
		{err_count, comparisons, cycles} = 96'h0;
		t_init;
		t_unsecure;
		t_keys;
		t_fault;
		finish_test;
	end
endmodule // test_fsic_ctrl
